// ### logic/urs_dev_end.sv
/*
  Device end: answers the identifier read command, serves the state and data
  registers, limits current, hibernates with context kept, and sleeps when idle.
  Assumes the host keeps the frame order and waits between transactions.
*/
`timescale 1ns/1ps
`include "urs_defs.svh"
module urs_dev_end #(
  parameter logic [199:0] UID_VALUE = {25{8'hA5}}, // Arbitrary value
  parameter logic [15:0]  BUILD_BCD = 16'h0101      // Arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  urs_link_if.dev          lk,
  input  wire logic [3:0]  ilim_req,    // Requested current limit, mA
  input  wire logic [15:0] sleep_delay, // Idle cycles before sleep
  input  wire logic        hib_req,     // Supply is about to be removed
  input  wire logic        hib_wake,    // Supply has returned
  output logic      [3:0]  ilim,        // Applied current limit, mA
  output logic             asleep,      // Low-power sleep active
  output logic             pwr_en       // Core supplied
);
  urs_pkg::urs_dev_t s;      // Registered state
  urs_pkg::urs_dev_t next_s; // Next state
  logic [15:0]       crc;    // Checksum over bytes served so far
  logic              crc_en; // Fold the byte just served
  logic              idle;   // Nothing to do this cycle

  // Byte i of the response; the tail uses the running checksum
  function automatic logic [7:0] rsp_byte(input logic [5:0] i, input logic [15:0] c);
    logic [7:0] b;
    b = 8'h00;
    if (i < 6'd8) begin
      b = urs_pkg::byte_of({`URS_RSP_HDR, 72'h0}, i);
    end else if (i < 6'd33) begin
      b = 8'(UID_VALUE >> (8 * (6'd32 - i)));
    end else if (i == 6'd33) begin
      b = BUILD_BCD[15:8];
    end else if (i == 6'd34) begin
      b = BUILD_BCD[7:0];
    end else if (i == 6'd35) begin
      b = c[15:8];
    end else begin
      b = c[7:0];
    end
    return b;
  endfunction

  // Byte i of the interface state register
  function automatic logic [7:0] state_byte(input logic [1:0] i, input urs_pkg::urs_ctx_t c);
    logic [7:0] b;
    b = 8'h00;
    unique case (i)
      2'd0: b = c.cmd_pend ? `URS_ST_BUSY : (c.rsp_rdy ? `URS_ST_READY : `URS_ST_IDLE);
      2'd1: b = `URS_ST_B1;
      2'd2: b = 8'h00;
      2'd3: b = c.rsp_rdy ? {2'b00, `URS_RSP_LEN} : 8'h00;
    endcase
    return b;
  endfunction

  // Checksum covers bytes 0 to 34 as they leave; restarts at each address take
  assign crc_en = s.rvalid & s.rnw & (s.reg_sel == `URS_REG_DATA) & (s.cnt <= 6'd35);

  urs_crc16 urs_crc16_inst (
    .clk   (clk),
    .rst_n (rst_n),
    .clr   (s.aack),
    .en    (crc_en),
    .din   (s.rdata),
    .crc   (crc)
  );

  // Idle: awake, no transaction, no command, no address on the link
  assign idle = (s.mode == urs_pkg::URS_AWAKE) & ~s.in_xfer & ~s.core.cmd_pend & ~lk.start;

  // Next state of the whole device
  always_comb begin
    next_s        = s;
    next_s.aack   = 1'b0;
    next_s.anack  = 1'b0;
    next_s.rvalid = 1'b0;

    // Core tasks run only while supplied
    if (s.mode != urs_pkg::URS_HIBER) begin
      next_s.core.ilim = (ilim_req < `URS_ILIM_MIN) ? `URS_ILIM_MIN : ilim_req;
      if (s.core.cmd_pend) begin
        if (s.core.proc_cnt == 8'h00) begin
          next_s.core.cmd_pend = 1'b0;
          next_s.core.rsp_rdy  = 1'b1;
          next_s.core.sec_cnt  = `URS_SEC_CYC; // Counter countdown follows each command
        end else begin
          next_s.core.proc_cnt = s.core.proc_cnt - 8'h01;
        end
      end else if (s.core.sec_cnt != 8'h00) begin
        next_s.core.sec_cnt = s.core.sec_cnt - 8'h01;
      end
    end

    // Delay to sleep: count while idle, restart on any activity
    if (!idle) begin
      next_s.idle_cnt = 16'h0000;
    end else if (s.idle_cnt >= sleep_delay) begin
      next_s.mode = urs_pkg::URS_GOSLEEP;
    end else begin
      next_s.idle_cnt = s.idle_cnt + 16'h0001;
    end

    // Go-to-sleep waits for idle tasks to drain
    if (s.mode == urs_pkg::URS_GOSLEEP && s.core.sec_cnt == 8'h00 && !s.core.cmd_pend) begin
      next_s.mode = urs_pkg::URS_SLEEP;
    end

    // Address phase
    if (lk.start && lk.addr == `URS_SLAVE_ADDR) begin
      unique case (s.mode)
        urs_pkg::URS_AWAKE, urs_pkg::URS_GOSLEEP: begin
          if (s.core.cmd_pend) begin
            next_s.anack = 1'b1;
          end else begin
            next_s.aack    = 1'b1;
            next_s.in_xfer = 1'b1;
            next_s.rnw     = lk.rnw;
            next_s.first   = ~lk.rnw;
            next_s.cnt     = 6'd0;
            next_s.cmd_ok  = 1'b1;
            next_s.ack_ok  = 1'b1;
          end
          next_s.mode = urs_pkg::URS_AWAKE;
        end
        urs_pkg::URS_SLEEP: begin
          // Waking takes the address time; the host retries
          next_s.anack = 1'b1;
          next_s.mode  = urs_pkg::URS_AWAKE;
        end
        urs_pkg::URS_HIBER: begin
          next_s.anack = 1'b1; // Unsupplied: address not acknowledged
        end
      endcase
    end

    // Write bytes: register selector first, then frame bytes
    if (s.in_xfer && lk.wvalid && !s.rnw) begin
      if (s.first) begin
        next_s.reg_sel = lk.wdata;
        next_s.first   = 1'b0;
      end else begin
        next_s.cmd_ok = s.cmd_ok & (lk.wdata == urs_pkg::byte_of(`URS_CMD_FRAME, s.cnt + 6'd1));
        next_s.ack_ok = s.ack_ok &
                        (lk.wdata == urs_pkg::byte_of({`URS_ACK_FRAME, 88'h0}, s.cnt + 6'd1));
        next_s.cnt    = s.cnt + 6'd1;
      end
    end

    // Read bytes from the selected register
    if (s.in_xfer && lk.rreq && s.rnw) begin
      next_s.rvalid = 1'b1;
      next_s.cnt    = s.cnt + 6'd1;
      if (s.reg_sel == `URS_REG_STATE) begin
        next_s.rdata = state_byte(s.cnt[1:0], s.core);
      end else if (s.reg_sel == `URS_REG_DATA && s.core.rsp_rdy) begin
        next_s.rdata = rsp_byte(s.cnt, crc);
      end else begin
        next_s.rdata = 8'h00; // Nothing to read here
      end
    end

    // Stop: act on a complete, matching frame
    if (s.in_xfer && lk.stop) begin
      next_s.in_xfer = 1'b0;
      if (!s.rnw && s.reg_sel == `URS_REG_DATA) begin
        if (s.cnt == `URS_CMD_LEN - 6'd1 && s.cmd_ok && !s.core.rsp_rdy) begin
          next_s.core.cmd_pend = 1'b1;
          next_s.core.proc_cnt = `URS_PROC_CYC;
        end else if (s.cnt == `URS_ACK_LEN - 6'd1 && s.ack_ok) begin
          next_s.core.rsp_rdy = 1'b0;
        end
      end
    end

    // Hibernation: save then drop supply; restore on return
    if (s.mode != urs_pkg::URS_HIBER && hib_req && !s.in_xfer) begin
      next_s.saved  = s.core;
      next_s.core   = '0;
      // Applied limit holds its last value, so it never reads outside 6..15
      next_s.core.ilim = s.core.ilim;
      next_s.mode   = urs_pkg::URS_HIBER;
      next_s.pwr_en = 1'b0;
    end else if (s.mode == urs_pkg::URS_HIBER && hib_wake) begin
      next_s.core   = s.saved;
      next_s.mode   = urs_pkg::URS_AWAKE;
      next_s.pwr_en = 1'b1;
    end

    next_s.asleep = (next_s.mode == urs_pkg::URS_SLEEP);
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s           <= '0;
      s.mode      <= urs_pkg::URS_AWAKE;
      s.core.ilim <= `URS_ILIM_MAX;
      s.pwr_en    <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign lk.aack   = s.aack;
  assign lk.anack  = s.anack;
  assign lk.rvalid = s.rvalid;
  assign lk.rdata  = s.rdata;
  assign ilim      = s.core.ilim;
  assign asleep    = s.asleep;
  assign pwr_en    = s.pwr_en;
endmodule // urs_dev_end

// ### logic/urs_defs.svh
/*
  Constants shared by both ends of the unique-id read and sleep control link:
  register selectors, frame images, status bytes, timing figures.
  Assumes it is included by bare name from files that need the values.
*/
`ifndef URS_DEFS_SVH
`define URS_DEFS_SVH

`define URS_SLAVE_ADDR  7'h30
`define URS_REG_DATA    8'h80
`define URS_REG_STATE   8'h82
// Command frame, register byte first, checksum last
`define URS_CMD_FRAME   136'h8004000B00_01000006_E0C20000_0064F09F
`define URS_CMD_LEN     6'd17
// Acknowledgement frame for frame number one
`define URS_ACK_FRAME   48'h808100005630
`define URS_ACK_LEN     6'd6
// Response: framing header then start of the identifier record
`define URS_RSP_HDR     64'h05002000_00001BCD
`define URS_RSP_LEN     6'd37
`define URS_ST_LEN      6'd4
`define URS_ST_IDLE     8'h08
`define URS_ST_READY    8'h48
`define URS_ST_BUSY     8'hC8
`define URS_ST_B1       8'h80
`define URS_ST_EXPECT   32'h48800025
// Current limit range in mA
`define URS_ILIM_MIN    4'h6
`define URS_ILIM_MAX    4'hF
// Timing
`define URS_CLK_NS      8
`define URS_GUARD_NS    50000
`define URS_RETRY_NS    100000000
`define URS_PROC_CYC    8'h40
`define URS_SEC_CYC     8'h20
`define URS_CRC_INIT    16'hFFFF
`define URS_CRC_POLY    16'h1021

`endif

// ### logic/urs_pkg.sv
/*
  Types for the unique-id read and sleep control ends, plus the frame byte
  picker used by both ends.
  Assumes urs_defs.svh supplies the numeric constants.
*/
package urs_pkg;

  typedef enum logic [3:0] {
    URS_AWAKE   = 4'h1,
    URS_GOSLEEP = 4'h2,
    URS_SLEEP   = 4'h4,
    URS_HIBER   = 4'h8
  } urs_mode_t;

  // Everything that survives hibernation
  typedef struct packed {
    logic       cmd_pend;
    logic [7:0] proc_cnt;
    logic       rsp_rdy;
    logic [7:0] sec_cnt;
    logic [3:0] ilim;
  } urs_ctx_t;

  typedef struct packed {
    urs_mode_t   mode;
    urs_ctx_t    core;
    urs_ctx_t    saved;
    logic        in_xfer;
    logic        rnw;
    logic        first;
    logic [7:0]  reg_sel;
    logic [5:0]  cnt;
    logic        cmd_ok;
    logic        ack_ok;
    logic [15:0] idle_cnt;
    logic        aack;
    logic        anack;
    logic        rvalid;
    logic [7:0]  rdata;
    logic        pwr_en;
    logic        asleep;
  } urs_dev_t;

  typedef enum logic [6:0] {
    URS_H_IDLE  = 7'h01,
    URS_H_START = 7'h02,
    URS_H_WAITA = 7'h04,
    URS_H_BYTE  = 7'h08,
    URS_H_WAITR = 7'h10,
    URS_H_STOP  = 7'h20,
    URS_H_GUARD = 7'h40
  } urs_hstate_t;

  typedef struct packed {
    urs_hstate_t  st;
    logic [2:0]   step;
    logic [5:0]   idx;
    logic [12:0]  gcnt;
    logic [23:0]  tcnt;
    logic         retry;
    logic         st_ok;
    logic         start;
    logic         rnw;
    logic         wvalid;
    logic [7:0]   wdata;
    logic         rreq;
    logic         stop;
    logic         busy;
    logic         done;
    logic         fail;
    logic [199:0] uid;
    logic [15:0]  build;
  } urs_host_t;

  typedef struct packed {
    logic [15:0] crc;
  } urs_crc_t;

  // Byte i of a frame image held most significant byte first
  function automatic logic [7:0] byte_of(input logic [135:0] f, input logic [5:0] i);
    return 8'(f >> (8 * (6'd16 - i)));
  endfunction

endpackage

// ### logic/urs_link_if.sv
/*
  Byte-level link between the host end and the device end: address phase,
  write bytes, read byte requests and a stop marker.
  Assumes both ends run on the same clock; the bench joins them.
*/
`timescale 1ns/1ps
interface urs_link_if;
  logic       start;  // Host: address phase, one cycle
  logic       rnw;    // Host: 1 read, 0 write, valid with start
  logic [6:0] addr;   // Host: slave address, valid with start
  logic       wvalid; // Host: write byte strobe
  logic [7:0] wdata;  // Host: write byte
  logic       rreq;   // Host: ask for the next read byte
  logic       stop;   // Host: end of transaction, one cycle
  logic       aack;   // Device: address taken
  logic       anack;  // Device: address refused
  logic       rvalid; // Device: read byte strobe
  logic [7:0] rdata;  // Device: read byte

  modport dev  (input start, rnw, addr, wvalid, wdata, rreq, stop,
                output aack, anack, rvalid, rdata);
  modport host (output start, rnw, addr, wvalid, wdata, rreq, stop,
                input aack, anack, rvalid, rdata);
endinterface

// ### logic/urs_crc16.sv
/*
  Running two-byte checksum over the bytes of a response frame.
  Assumes clr and en never need to act in the same cycle usefully; clr wins.
*/
`timescale 1ns/1ps
`include "urs_defs.svh"
module urs_crc16 (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        clr,    // Restart at the seed
  input  wire logic        en,     // Fold din in
  input  wire logic [7:0]  din,    // Byte to fold
  output logic      [15:0] crc     // Current checksum
);
  urs_pkg::urs_crc_t s;      // Registered state
  urs_pkg::urs_crc_t next_s; // Next state

  // One byte folded per cycle, msb first
  always_comb begin
    logic [15:0] c;
    c = s.crc;
    for (int k = 7; k >= 0; k--) begin
      if (c[15] ^ din[k]) begin
        c = {c[14:0], 1'b0} ^ `URS_CRC_POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    next_s = s;
    if (clr) begin
      next_s.crc = `URS_CRC_INIT;
    end else if (en) begin
      next_s.crc = c;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s.crc <= `URS_CRC_INIT;
    end else begin
      s <= next_s;
    end
  end

  assign crc = s.crc;
endmodule // urs_crc16

// ### logic/urs_host_end.sv
/*
  Host end: on go, sends the identifier read command, polls the state
  register, reads the response, and acknowledges it, with retries and guard.
  Assumes one device on the link at the fixed slave address.
*/
`timescale 1ns/1ps
`include "urs_defs.svh"
module urs_host_end #(
  parameter int GUARD_CYC = (`URS_GUARD_NS + `URS_CLK_NS - 1) / `URS_CLK_NS, // 6250
  parameter int RETRY_CYC = `URS_RETRY_NS / `URS_CLK_NS                    // 12500000
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  urs_link_if.host          lk,
  input  wire logic         go,    // Start one identifier read
  output logic              busy,  // Sequence running
  output logic              done,  // Sequence finished, one cycle
  output logic              fail,  // Retry window ran out, one cycle
  output logic      [199:0] uid,   // Unique id bytes of the last response
  output logic      [15:0]  build  // Build number of the last response
);
  urs_pkg::urs_host_t s;      // Registered state
  urs_pkg::urs_host_t next_s; // Next state
  logic [5:0]         len;    // Bytes in the current transaction
  logic               is_rd;  // Current step reads

  // Step table: 0 command, 1 select state, 2 read state,
  // 3 select data, 4 read data, 5 acknowledge
  function automatic logic [135:0] frame_of(input logic [2:0] st);
    logic [135:0] f;
    f = '0;
    unique case (st)
      3'd0:    f = `URS_CMD_FRAME;
      3'd1:    f = {`URS_REG_STATE, 128'h0};
      3'd3:    f = {`URS_REG_DATA, 128'h0};
      3'd5:    f = {`URS_ACK_FRAME, 88'h0};
      default: f = '0;
    endcase
    return f;
  endfunction

  always_comb begin
    unique case (s.step)
      3'd0:    len = `URS_CMD_LEN;
      3'd2:    len = `URS_ST_LEN;
      3'd4:    len = `URS_RSP_LEN;
      3'd5:    len = `URS_ACK_LEN;
      default: len = 6'd1;
    endcase
  end
  assign is_rd = (s.step == 3'd2) | (s.step == 3'd4);

  // Sequencer
  always_comb begin
    next_s        = s;
    next_s.start  = 1'b0;
    next_s.wvalid = 1'b0;
    next_s.rreq   = 1'b0;
    next_s.stop   = 1'b0;
    next_s.done   = 1'b0;
    next_s.fail   = 1'b0;
    if (s.busy) begin
      next_s.tcnt = s.tcnt + 24'h000001;
    end
    unique case (s.st)
      urs_pkg::URS_H_IDLE: begin
        if (go) begin
          next_s.st   = urs_pkg::URS_H_START;
          next_s.step = 3'd0;
          next_s.tcnt = 24'h000000;
          next_s.busy = 1'b1;
        end
      end
      urs_pkg::URS_H_START: begin
        next_s.start = 1'b1;
        next_s.rnw   = is_rd;
        next_s.idx   = 6'd0;
        next_s.st_ok = 1'b1;
        next_s.st    = urs_pkg::URS_H_WAITA;
      end
      urs_pkg::URS_H_WAITA: begin
        if (lk.aack) begin
          next_s.tcnt = 24'h000000;
          next_s.st   = urs_pkg::URS_H_BYTE;
        end else if (lk.anack) begin
          next_s.retry = 1'b1;
          next_s.st    = urs_pkg::URS_H_GUARD;
        end
      end
      urs_pkg::URS_H_BYTE: begin
        if (is_rd) begin
          next_s.rreq = 1'b1;
          next_s.st   = urs_pkg::URS_H_WAITR;
        end else begin
          next_s.wvalid = 1'b1;
          next_s.wdata  = urs_pkg::byte_of(frame_of(s.step), s.idx);
          next_s.idx    = s.idx + 6'd1;
          if (s.idx == len - 6'd1) begin
            next_s.st = urs_pkg::URS_H_STOP;
          end
        end
      end
      urs_pkg::URS_H_WAITR: begin
        if (lk.rvalid) begin
          if (s.step == 3'd2) begin
            next_s.st_ok = s.st_ok &
                           (lk.rdata == 8'(`URS_ST_EXPECT >> (8 * (6'd3 - s.idx))));
          end else if (s.idx >= 6'd8 && s.idx < 6'd33) begin
            next_s.uid = {s.uid[191:0], lk.rdata};
          end else if (s.idx == 6'd33 || s.idx == 6'd34) begin
            next_s.build = {s.build[7:0], lk.rdata};
          end
          next_s.idx = s.idx + 6'd1;
          next_s.st  = (s.idx == len - 6'd1) ? urs_pkg::URS_H_STOP : urs_pkg::URS_H_BYTE;
        end
      end
      urs_pkg::URS_H_STOP: begin
        next_s.stop  = 1'b1;
        next_s.retry = 1'b0;
        next_s.st    = urs_pkg::URS_H_GUARD;
      end
      urs_pkg::URS_H_GUARD: begin
        // Guard after every transaction covers read-to-write spacing
        if (s.gcnt == 13'(GUARD_CYC - 1)) begin
          next_s.gcnt = 13'h0000;
          next_s.st   = urs_pkg::URS_H_START;
          if (s.retry) begin
            next_s.st = urs_pkg::URS_H_START;
          end else if (s.step == 3'd2 && !s.st_ok) begin
            next_s.step = 3'd1;
          end else if (s.step == 3'd5) begin
            next_s.st   = urs_pkg::URS_H_IDLE;
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
          end else begin
            next_s.step = s.step + 3'd1;
          end
        end else begin
          next_s.gcnt = s.gcnt + 13'h0001;
        end
      end
    endcase
    // A device that keeps refusing ends the sequence
    if (s.busy && s.tcnt == 24'(RETRY_CYC - 1)) begin
      next_s       = s;
      next_s.st    = urs_pkg::URS_H_IDLE;
      next_s.busy  = 1'b0;
      next_s.fail  = 1'b1;
      next_s.gcnt  = 13'h0000;
      next_s.start = 1'b0;
      next_s.wvalid = 1'b0;
      next_s.rreq  = 1'b0;
      next_s.stop  = 1'b0;
      next_s.done  = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s    <= '0;
      s.st <= urs_pkg::URS_H_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign lk.start  = s.start;
  assign lk.rnw    = s.rnw;
  assign lk.addr   = `URS_SLAVE_ADDR;
  assign lk.wvalid = s.wvalid;
  assign lk.wdata  = s.wdata;
  assign lk.rreq   = s.rreq;
  assign lk.stop   = s.stop;
  assign busy      = s.busy;
  assign done      = s.done;
  assign fail      = s.fail;
  assign uid       = s.uid;
  assign build     = s.build;
endmodule // urs_host_end

// ### tb/urs_monitor.sv
/*
  Checker for the byte link joining host end and device end.
  Assumes the bench feeds it the link signals with the shared clock and reset.
*/
`timescale 1ns/1ps
module urs_monitor (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       start,
  input wire logic [6:0] addr,
  input wire logic       wvalid,
  input wire logic       rreq,
  input wire logic       stop,
  input wire logic       aack,
  input wire logic       anack,
  input wire logic       rvalid,
  input wire logic [7:0] rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // One answer, next cycle, for our own address
  addr_answer_a: assert property (start && addr == 7'h30 |=> aack ^ anack)
    else $error("address phase not answered");
  ack_cause_a: assert property (aack || anack |-> $past(start))
    else $error("address answer without address phase");
  ack_pulse_a: assert property (aack |=> !aack)
    else $error("address acknowledge longer than one cycle");
  // Read bytes only ever answer a request
  read_answer_a: assert property (rvalid |-> $past(rreq))
    else $error("read byte without request");
  rdata_hold_a: assert property (!rvalid |-> $stable(rdata))
    else $error("read data moved without strobe");
  read_pace_a: assert property (rvalid |=> !rreq)
    else $error("read request too soon after byte");
  // Guard gap keeps a fresh start away from the last one
  start_guard_a: assert property (start |=> !start [*3])
    else $error("address phases too close");
  stop_clean_a: assert property (stop |-> !wvalid && !rreq)
    else $error("stop mixed with byte traffic");

  cover property (anack);
  cover property (aack ##1 !aack);
  cover property (rvalid && rdata == 8'h25);
endmodule // urs_monitor

// ### tb/uid_read_and_sleep_control_test.sv
/*
  Self-checking bench: host end and device end joined by the link.
  Assumes the shared defines header is on the include path.
*/
`timescale 1ns/1ps
`include "urs_defs.svh"
module uid_read_and_sleep_control_test;
  logic         clk, rst_n, go, hib_req, hib_wake;
  logic [3:0]   ilim_req, ilim;
  logic [15:0]  sleep_delay, build;
  logic         busy, done, fail, asleep, pwr_en;
  logic [199:0] uid;
  int           errors, n_checks, nack_seen;
  logic [7:0]   rq[$];   // Bytes read by the host
  logic [7:0]   wq[$];   // Bytes written by the host
  // Rows: requested limit, applied limit (low values clamp)
  logic [7:0]   rows [5] = '{8'h06, 8'h56, 8'h66, 8'hAA, 8'hFF};
  // Distinct id bytes, so a wrong byte order shows on the wire
  localparam logic [199:0] UID_EXP   = 200'h0102030405060708090A0B0C0D0E0F10111213141516171819;
  localparam logic [15:0]  BUILD_EXP = 16'h0123;

  urs_link_if lk();
  // Short guard and retry keep the run small
  urs_host_end #(.GUARD_CYC(4), .RETRY_CYC(2000)) urs_host_end_inst (
    .clk(clk), .rst_n(rst_n), .lk(lk), .go(go), .busy(busy), .done(done),
    .fail(fail), .uid(uid), .build(build));
  urs_dev_end #(.UID_VALUE(UID_EXP), .BUILD_BCD(BUILD_EXP)) urs_dev_end_inst (
    .clk(clk), .rst_n(rst_n), .lk(lk), .ilim_req(ilim_req),
    .sleep_delay(sleep_delay), .hib_req(hib_req), .hib_wake(hib_wake),
    .ilim(ilim), .asleep(asleep), .pwr_en(pwr_en));
  urs_monitor urs_monitor_inst (
    .clk(clk), .rst_n(rst_n), .start(lk.start), .addr(lk.addr),
    .wvalid(lk.wvalid), .rreq(lk.rreq), .stop(lk.stop), .aack(lk.aack),
    .anack(lk.anack), .rvalid(lk.rvalid), .rdata(lk.rdata));

  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  // Record wire traffic so frames are judged on the link itself; sampled
  // mid-cycle, where strobes launched at the rising edge stand settled
  always @(negedge clk) begin
    if (lk.rvalid === 1'h1) rq.push_back(lk.rdata);
    if (lk.wvalid === 1'h1) wq.push_back(lk.wdata);
    if (lk.anack === 1'h1) nack_seen++;
  end

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task print_verdict;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Bounded wait for done, or for sleep; a fail pulse is a mismatch
  task wait_for(input int lim, input bit slp);
    for (int i = 0; i < lim; i++) begin
      @(negedge clk);
      if (fail === 1'h1) check("fail", fail, 1'h0);
      if (slp ? asleep === 1'h1 : done === 1'h1) return;
    end
    errors++;
    $display("Error wait expected event seen none");
    print_verdict();
  endtask

  // Checksum worked out independently over response bytes 0..34
  function automatic logic [15:0] crc_of(input int b);
    logic [15:0] c;
    c = `URS_CRC_INIT;
    for (int i = 0; i < 35; i++) begin
      c ^= {rq[b+i], 8'h00};
      for (int k = 0; k < 8; k++) c = c[15] ? (c << 1) ^ `URS_CRC_POLY : c << 1;
    end
    return c;
  endfunction

  // One whole identifier read, then the frames seen on the wire; with hib set
  // the device hibernates while the command is pending, so only a restored
  // context lets the sequence finish
  task run_read(input bit hib);
    int b;
    rq.delete();
    wq.delete();
    go = 1'h1;
    @(negedge clk);
    go = 1'h0;
    check("busy", busy, 1'h1);
    if (hib) begin
      repeat (40) @(negedge clk);
      hib_req = 1'h1;
      @(negedge clk);
      hib_req = 1'h0;
      ilim_req = 4'hC;
      @(negedge clk);
      check("pwr_off", pwr_en, 1'h0);
      check("ilim_frz", ilim, 4'h9);
      repeat (20) @(negedge clk);
      hib_wake = 1'h1;
      @(negedge clk);
      hib_wake = 1'h0;
      @(negedge clk);
      check("pwr_on", pwr_en, 1'h1);
    end
    wait_for(3000, 1'b0);
    check("idle", busy, 1'h0);
    b = rq.size() - 37;
    check("uid", uid === UID_EXP, 1'h1);
    check("build", build, BUILD_EXP);
    for (int i = 0; i < 25; i++) check("uid_byte", rq[b+8+i], 8'(UID_EXP >> (192-8*i)));
    for (int i = 0; i < 4; i++) check("state", rq[b-4+i], 8'(`URS_ST_EXPECT >> (24-8*i)));
    for (int i = 0; i < 8; i++) check("hdr", rq[b+i], 8'(`URS_RSP_HDR >> (56-8*i)));
    check("crc", {rq[b+35], rq[b+36]}, crc_of(b));
    for (int i = 0; i < 17; i++) check("cmd", wq[i], 8'(`URS_CMD_FRAME >> (128-8*i)));
    for (int i = 0; i < 6; i++) check("ack", wq[wq.size()-6+i], 8'(`URS_ACK_FRAME >> (40-8*i)));
  endtask

  initial begin
    {rst_n, go, hib_req, hib_wake, errors, n_checks, nack_seen} = '0;
    ilim_req = 4'hF;
    sleep_delay = 16'hFFFF;
    repeat (10) @(negedge clk);
    check("ilim_rst", ilim, 4'hF);
    check("pwr_rst", pwr_en, 1'h1);
    rst_n = 1'h1;
    // Current-limit table
    foreach (rows[r]) begin
      ilim_req = rows[r][7:4];
      repeat (2) @(negedge clk);
      check("ilim", ilim, rows[r][3:0]);
    end
    run_read(1'b0);
    check("refused", nack_seen > 0, 1'h1);
    // Hibernate in mid-command: limit frozen, supply off, then resume
    ilim_req = 4'h9;
    run_read(1'b1);
    // Short idle delay: sleep, then wake by address
    sleep_delay = 16'h0010;
    wait_for(200, 1'b1);
    check("asleep", asleep, 1'h1);
    run_read(1'b0);
    check("awake", asleep, 1'h0);
    repeat (10) @(negedge clk);
    check("delay", asleep, 1'h0);
    wait_for(200, 1'b1);
    // Reset in mid-run
    rst_n = 1'h0;
    @(negedge clk);
    check("slp_rst", asleep, 1'h0);
    check("ilim_rst2", ilim, 4'hF);
    rst_n = 1'h1;
    @(negedge clk);
    check("ilim_rel", ilim, 4'hC);
    check("busy_rel", busy, 1'h0);
    print_verdict();
  end
endmodule // uid_read_and_sleep_control_test
